// ==== hw/adc_pkg.sv ====
/*
  Shared constants for the serial converter control block: control word
  layout, frame timing, power modes and the register map seen over APB.
  Assumes nothing of its surroundings; each design file that uses it refers to it by
  its package name.
*/
package adc_pkg;

  // ----------------------------------------------------------------------
  // Control word layout
  // ----------------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int REF_DISABLE_BIT = 5;
  localparam int CHANNEL_COUNT_SELECT_BIT = 4;
  localparam int CHANNEL_CHOICE_BIT = 3;
  localparam int POWER_MODE_HIGH_BIT = 1;
  localparam int POWER_MODE_LOW_BIT = 0;

  // ----------------------------------------------------------------------
  // Frame timing, counted in serial clock edges after select falls
  // ----------------------------------------------------------------------
  localparam logic [4:0] CTRL_BITS = 5'h08;
  localparam logic [4:0] FRAME_CLOCKS = 5'h10;
  localparam logic [4:0] LEAD_ZEROS = 5'h04;
  localparam logic [4:0] SAMPLE_RISE_INDEX = 5'h01;
  localparam logic [4:0] LAST_STEP_RISE_INDEX = 5'h0d;
  localparam logic [4:0] COUNT_MAX = 5'h1f;
  localparam logic [4:0] MSB_POSITION = 5'h0f;
  localparam logic [11:0] SAR_FIRST_TRIAL = 12'h800;

  // ----------------------------------------------------------------------
  // Power modes and power states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PM_SELECT_CONTROLLED = 2'b00,
    PM_ALWAYS_ON = 2'b01,
    PM_AUTO_SHUTDOWN = 2'b10,
    PM_AUTO_STANDBY = 2'b11
  } power_mode_t;

  typedef enum logic [1:0] {
    PWR_OFF = 2'b00,
    PWR_STANDBY = 2'b01,
    PWR_ON = 2'b10
  } power_state_t;

  // ----------------------------------------------------------------------
  // APB register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_RESULT = 8'h08;
  localparam int STAT_POWER_LSB = 8;
  localparam int STAT_HOLD_BIT = 10;

endpackage : adc_pkg

// ==== hw/pin_sync.sv ====
/*
  Two-stage synchroniser for a group of independent level inputs.
  Assumes each bit is a level from outside the clk domain; the first stage
  is read by the second stage only.
*/
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      stage1 <= INIT;
      sync_out <= INIT;
    end
    else
    begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : pin_sync

// ==== hw/sar_engine.sv ====
/*
  Successive-approximation register for a 12-bit straight binary result.
  Assumes start and step are single-cycle pulses derived from serial clock
  rising edges and that compare_high is already synchronised to clk.
*/
`timescale 1ns/100ps
module sar_engine (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire logic step,
  input wire logic compare_high,
  output logic [11:0] trial,
  output logic [11:0] result,
  output logic hold
);

  logic [11:0] mask;
  logic [11:0] next_trial;
  logic [11:0] next_result;
  logic [11:0] next_mask;
  logic next_hold;

  // ----------------------------------------------------------------------
  // Binary search, one decision per step
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_trial = trial;
    next_result = result;
    next_mask = mask;
    next_hold = hold;
    if (start)
    begin
      next_trial = adc_pkg::SAR_FIRST_TRIAL;
      next_mask = adc_pkg::SAR_FIRST_TRIAL;
      next_hold = 1'b1;
    end
    else if (step && hold)
    begin
      // A trial code weight of one equals one step of reference/4096.
      next_trial = (compare_high ? trial : (trial & ~mask)) | (mask >> 1);
      next_mask = mask >> 1;
      if (mask == 12'h001)
      begin
        next_result = next_trial;
        next_hold = 1'b0;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      trial <= 12'h000;
      result <= 12'h000;
      mask <= 12'h000;
      hold <= 1'b0;
    end
    else
    begin
      trial <= next_trial;
      result <= next_result;
      mask <= next_mask;
      hold <= next_hold;
    end
  end

  property p_sar_start;
    @(posedge clk) disable iff (reset)
    start |=> (trial == 12'h800) && hold;
  endproperty
  a_sar_start: assert property (p_sar_start)
    else $error("conversion did not start at mid scale");

  property p_sar_reject;
    @(posedge clk) disable iff (reset)
    (step && hold && !start && !compare_high) |=>
      ((trial & $past(mask)) == 12'h000);
  endproperty
  a_sar_reject: assert property (p_sar_reject)
    else $error("rejected trial bit was kept");

endmodule : sar_engine

// ==== hw/serial_adc_power_control.sv ====
/*
  Control and readout logic of a 12-bit serial converter: control word
  capture, result framing, power-mode sequencing and an APB register view.
  Assumes select, serial clock, serial input and the comparator arrive from
  outside the clk domain; serial clock edges are found by sampling it.
*/
// Local design decisions: the register addresses and register access over APB.
// Contract
// - Mode 00: powered while select low, shut down while select high.
// - Mode 01: always fully powered regardless of inputs.
// - Mode 10: full shutdown automatically at the end of each conversion.
// - Mode 11: standby after each conversion, reference stays on.
// - Serial clock both shifts data and steps the conversion.
// - Results are unsigned straight binary, zero input gives code zero.
// - Code transitions at whole multiples of reference over 4096.
// - Result word: four zeros, then 12 result bits MSB first.
// - Dual-channel mode uses supply as reference.
// - Reference enabled when reference-disable is 0, off when 1.
// - Supports 125 kSPS with a 2 MHz serial clock.
// - 8-bit control word, MSB first, on first eight rises; 16 clocks.
// - Control word clears to zero at power-up.
// - Auto modes: down on 16th rise, up on first fall after select.
`timescale 1ns/100ps
module serial_adc_power_control (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic select_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic compare_high,
  output logic dout,
  output logic dout_oe,
  output logic [11:0] dac_code,
  output logic sample_hold,
  output logic powered_up,
  output logic standby,
  output logic ref_enable,
  output logic use_supply_ref,
  output logic channel_choice
);

  logic [3:0] pins_s;
  logic select_n_s;
  logic sclk_s;
  logic din_s;
  logic compare_s;
  logic select_q;
  logic sclk_q;
  logic cs_fall;
  logic in_frame;
  logic sclk_rise;
  logic sclk_fall;
  logic sar_start;
  logic sar_step;
  logic rise16;
  logic first_fall;
  logic [11:0] result;
  logic [4:0] rise_count;
  logic [4:0] fall_count;
  logic [6:0] shift;
  logic [7:0] ctrl;
  logic [4:0] next_rise_count;
  logic [4:0] next_fall_count;
  logic [6:0] next_shift;
  logic [7:0] next_ctrl;
  logic next_dout;
  logic next_dout_oe;
  adc_pkg::power_mode_t mode;
  adc_pkg::power_state_t power;
  adc_pkg::power_state_t next_power;
  logic apb_access;
  logic apb_write_ctrl;
  logic next_pready;
  logic [31:0] next_prdata;
  logic next_pslverr;

  function automatic logic serial_bit(input logic [4:0] n,
                                      input logic [11:0] code);
    logic bit_value;
    bit_value = 1'b0;
    if (n >= adc_pkg::LEAD_ZEROS && n < adc_pkg::FRAME_CLOCKS)
    begin
      bit_value = code[4'(adc_pkg::MSB_POSITION - n)];
    end
    return bit_value;
  endfunction : serial_bit

  // ----------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------------
  // Idle levels: select high, serial clock high, so no false edge at reset.
  pin_sync #(.WIDTH(4), .INIT(4'h3)) pins (
    .clk(clk),
    .reset(reset),
    .async_in({compare_high, din, sclk, select_n}),
    .sync_out(pins_s)
  );

  assign select_n_s = pins_s[0];
  assign sclk_s = pins_s[1];
  assign din_s = pins_s[2];
  assign compare_s = pins_s[3];
  assign cs_fall = select_q && !select_n_s;
  assign in_frame = !select_n_s && !cs_fall;
  // Sampling at 200 MHz leaves ample margin for a 2 MHz serial clock.
  assign sclk_rise = in_frame && sclk_s && !sclk_q;
  assign sclk_fall = in_frame && !sclk_s && sclk_q;
  // The converter has no clock of its own: serial edges step it.
  assign sar_start = sclk_rise &&
    (rise_count == adc_pkg::SAMPLE_RISE_INDEX);
  assign sar_step = sclk_rise && (rise_count > adc_pkg::SAMPLE_RISE_INDEX) &&
    (rise_count <= adc_pkg::LAST_STEP_RISE_INDEX);
  assign rise16 = sclk_rise &&
    (rise_count == adc_pkg::FRAME_CLOCKS - 5'h01);
  assign first_fall = sclk_fall && (fall_count == 5'h00);
  assign mode = adc_pkg::power_mode_t'(
    ctrl[adc_pkg::POWER_MODE_HIGH_BIT:adc_pkg::POWER_MODE_LOW_BIT]);

  sar_engine sar (
    .clk(clk),
    .reset(reset),
    .start(sar_start),
    .step(sar_step),
    .compare_high(compare_s),
    .trial(dac_code),
    .result(result),
    .hold(sample_hold)
  );

  // ----------------------------------------------------------------------
  // Frame: control word capture and result shifting
  // ----------------------------------------------------------------------
  assign apb_access = psel && penable && pready;
  assign apb_write_ctrl = apb_access && pwrite &&
    (paddr == adc_pkg::ADDR_CONTROL);

  always_comb
  begin
    next_rise_count = rise_count;
    next_fall_count = fall_count;
    next_shift = shift;
    next_ctrl = ctrl;
    next_dout = dout;
    next_dout_oe = dout_oe;
    if (apb_write_ctrl)
    begin
      next_ctrl = pwdata[7:0];
    end
    if (cs_fall)
    begin
      next_rise_count = 5'h00;
      next_fall_count = 5'h00;
      next_shift = 7'h00;
      next_dout = 1'b0;
      next_dout_oe = 1'b1;
    end
    else if (select_n_s)
    begin
      next_dout = 1'b0;
      next_dout_oe = 1'b0;
    end
    else
    begin
      if (sclk_rise)
      begin
        if (rise_count != adc_pkg::COUNT_MAX)
        begin
          next_rise_count = rise_count + 5'h01;
        end
        if (rise_count < adc_pkg::CTRL_BITS)
        begin
          next_shift = {shift[5:0], din_s};
        end
        // Serial load wins over a coincident APB write.
        if (rise_count == adc_pkg::CTRL_BITS - 5'h01)
        begin
          next_ctrl = {shift, din_s};
        end
      end
      if (sclk_fall)
      begin
        if (fall_count != adc_pkg::COUNT_MAX)
        begin
          next_fall_count = fall_count + 5'h01;
        end
        next_dout = serial_bit(fall_count + 5'h01, dac_code);
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      select_q <= 1'b1;
      sclk_q <= 1'b1;
      rise_count <= 5'h00;
      fall_count <= 5'h00;
      shift <= 7'h00;
      ctrl <= adc_pkg::CTRL_RESET;
      dout <= 1'b0;
      dout_oe <= 1'b0;
    end
    else
    begin
      select_q <= select_n_s;
      sclk_q <= sclk_s;
      rise_count <= next_rise_count;
      fall_count <= next_fall_count;
      shift <= next_shift;
      ctrl <= next_ctrl;
      dout <= next_dout;
      dout_oe <= next_dout_oe;
    end
  end

  // ----------------------------------------------------------------------
  // Power sequencing and analog controls
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_power = power;
    case (mode)
      adc_pkg::PM_SELECT_CONTROLLED:
      begin
        next_power = select_n_s ? adc_pkg::PWR_OFF : adc_pkg::PWR_ON;
      end
      adc_pkg::PM_ALWAYS_ON:
      begin
        next_power = adc_pkg::PWR_ON;
      end
      adc_pkg::PM_AUTO_SHUTDOWN, adc_pkg::PM_AUTO_STANDBY:
      begin
        if (rise16)
        begin
          next_power = (mode == adc_pkg::PM_AUTO_STANDBY) ?
            adc_pkg::PWR_STANDBY : adc_pkg::PWR_OFF;
        end
        else if (first_fall)
        begin
          next_power = adc_pkg::PWR_ON;
        end
      end
      default:
      begin
        next_power = adc_pkg::PWR_OFF;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      power <= adc_pkg::PWR_OFF;
      powered_up <= 1'b0;
      standby <= 1'b0;
      ref_enable <= 1'b0;
      use_supply_ref <= 1'b0;
      channel_choice <= 1'b0;
    end
    else
    begin
      power <= next_power;
      powered_up <= (next_power == adc_pkg::PWR_ON);
      standby <= (next_power == adc_pkg::PWR_STANDBY);
      // Standby keeps the reference alive so wake-up stays short.
      ref_enable <= !ctrl[adc_pkg::REF_DISABLE_BIT] &&
        (next_power != adc_pkg::PWR_OFF);
      use_supply_ref <= ctrl[adc_pkg::CHANNEL_COUNT_SELECT_BIT];
      channel_choice <= ctrl[adc_pkg::CHANNEL_COUNT_SELECT_BIT] &&
        ctrl[adc_pkg::CHANNEL_CHOICE_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // APB slave, one wait state on every access
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_pready = psel && penable && !pready;
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (next_pready)
    begin
      case (paddr)
        adc_pkg::ADDR_CONTROL: next_prdata = {24'h00_0000, ctrl};
        adc_pkg::ADDR_STATUS:
        begin
          next_prdata = 32'(rise_count) |
            (32'(power) << adc_pkg::STAT_POWER_LSB) |
            (32'(sample_hold) << adc_pkg::STAT_HOLD_BIT);
        end
        adc_pkg::ADDR_RESULT: next_prdata = {20'h0_0000, result};
        default: next_pslverr = 1'b1;
      endcase
      if (pwrite)
      begin
        next_prdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= next_pready;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_last_rise;
    rise16 && (power == adc_pkg::PWR_ON);
  endsequence

  property p_mode1;
    (mode == adc_pkg::PM_SELECT_CONTROLLED && select_n_s) |=> !powered_up;
  endproperty
  a_mode1: assert property (p_mode1)
    else $error("powered while deselected in select mode");

  property p_mode2;
    (mode == adc_pkg::PM_ALWAYS_ON) |=> powered_up;
  endproperty
  a_mode2: assert property (p_mode2)
    else $error("not powered in always-on mode");

  property p_auto_off;
    (s_last_rise and (mode == adc_pkg::PM_AUTO_SHUTDOWN)) |=>
      !powered_up && !standby && !ref_enable;
  endproperty
  a_auto_off: assert property (p_auto_off)
    else $error("no shutdown after 16th rise");

  property p_auto_standby;
    (s_last_rise and (mode == adc_pkg::PM_AUTO_STANDBY)) |=>
      standby && !powered_up;
  endproperty
  a_auto_standby: assert property (p_auto_standby)
    else $error("no standby after 16th rise");

  property p_wake;
    (first_fall && mode[adc_pkg::POWER_MODE_HIGH_BIT]) |=> powered_up;
  endproperty
  a_wake: assert property (p_wake)
    else $error("no power-up on first falling serial edge");

  property p_lead_zero;
    (sclk_fall && fall_count < adc_pkg::LEAD_ZEROS - 5'h01) |=> !dout;
  endproperty
  a_lead_zero: assert property (p_lead_zero)
    else $error("leading bit of result word not zero");

  property p_ctrl_load;
    (sclk_rise && rise_count == adc_pkg::CTRL_BITS - 5'h01) |=>
      (ctrl == {$past(shift), $past(din_s)});
  endproperty
  a_ctrl_load: assert property (p_ctrl_load)
    else $error("control word not loaded on eighth rise");

  property p_release;
    select_n_s ##1 select_n_s |-> !dout_oe;
  endproperty
  a_release: assert property (p_release)
    else $error("serial output driven while deselected");

  property p_ref;
    ctrl[adc_pkg::REF_DISABLE_BIT] |=> !ref_enable;
  endproperty
  a_ref: assert property (p_ref)
    else $error("reference on while disabled");

  property p_dual_ref;
    ctrl[adc_pkg::CHANNEL_COUNT_SELECT_BIT] |=> use_supply_ref;
  endproperty
  a_dual_ref: assert property (p_dual_ref)
    else $error("dual mode not using supply reference");

endmodule : serial_adc_power_control

// ==== verification/serial_host_model.sv ====
/*
  Host serial port model: drives select, serial clock and serial input,
  reads the 16-bit result word, and stands in for the analog comparator.
  Assumes the caller supplies the input level in steps of one code.
*/
`timescale 1ns/100ps
module serial_host_model (
  input wire logic [11:0] analog_level,
  input wire logic [11:0] dac_code,
  input wire logic dout,
  input wire logic dout_oe,
  output logic select_n,
  output logic sclk,
  output logic din,
  output logic compare_high
);
  // ----------------------------------------------------------------------
  // Comparator stand-in
  // ----------------------------------------------------------------------
  // Trial at or below the input reads high, so codes step on whole codes.
  assign compare_high = (analog_level >= dac_code);

  initial
  begin
    select_n = 1'b1;
    sclk = 1'b1;
    din = 1'b0;
  end

  // ----------------------------------------------------------------------
  // One transfer of sixteen serial clocks
  // ----------------------------------------------------------------------
  // The clock stands high between frames. Each bit is read just before
  // the falling edge that replaces it; a released line reads as pulled up.
  task automatic frame(input logic [7:0] ctrl, input realtime half,
                       output logic [15:0] word);
    int i;
    select_n <= 1'b0;
    #150;
    for (i = 0; i < 16; i++)
    begin
      word[15-i] = dout_oe ? dout : 1'b1;
      sclk <= 1'b0;
      if (i < 8)
        din <= ctrl[7-i];
      else
        din <= ~din;
      #(half);
      sclk <= 1'b1;
      #(half);
    end
    #50;
    select_n <= 1'b1;
    din <= ~din;
    #150;
  endtask : frame
endmodule : serial_host_model

// ==== verification/serial_adc_power_control_tb.sv ====
/*
  Self-checking bench: APB register access, serial frames in all power
  modes with corner and random input levels.
  Assumes the host model above on the serial side.
*/
`timescale 1ns/100ps
module serial_adc_power_control_tb;
  logic clk, reset, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic select_n, sclk, din, compare_high, dout, dout_oe, err;
  logic [11:0] dac_code, analog_level;
  logic sample_hold, powered_up, standby, ref_enable;
  logic use_supply_ref, channel_choice;
  logic [11:0] corners [4] = '{12'h000, 12'hfff, 12'h800, 12'h7ff};
  int miscompares, cmp_count, k;
  logic [31:0] rnd;
  logic [1:0] m;

  serial_adc_power_control serial_adc_power_control_inst (.clk(clk),
    .reset(reset), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .select_n(select_n), .sclk(sclk), .din(din),
    .compare_high(compare_high), .dout(dout), .dout_oe(dout_oe),
    .dac_code(dac_code), .sample_hold(sample_hold),
    .powered_up(powered_up), .standby(standby), .ref_enable(ref_enable),
    .use_supply_ref(use_supply_ref), .channel_choice(channel_choice));

  serial_host_model serial_host_model_inst (.analog_level(analog_level),
    .dac_code(dac_code), .dout(dout), .dout_oe(dout_oe),
    .select_n(select_n), .sclk(sclk),
    .din(din), .compare_high(compare_high));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    if (miscompares == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  // ----------------------------------------------------------------------
  // APB master
  // ----------------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // ----------------------------------------------------------------------
  // Expectations
  // ----------------------------------------------------------------------
  // Returns {powered_up, standby}; busy means select still low.
  function automatic logic [1:0] exp_power(input logic [1:0] mode,
                                           input logic busy);
    case (mode)
      2'b00: return {busy, 1'b0};
      2'b01: return 2'b10;
      2'b10: return 2'b00;
      default: return 2'b01;
    endcase
  endfunction : exp_power

  task automatic run_frame(input logic [7:0] ctrl, input logic [11:0] lvl,
                           input realtime half);
    logic [15:0] word;
    logic [31:0] r;
    logic e;
    analog_level <= lvl;
    @(posedge clk);
    fork
      serial_host_model_inst.frame(ctrl, half, word);
      begin
        #(150 + 8 * half + 20);
        check(powered_up, 1'b1);
        check(dout_oe, 1'b1);
        #(24 * half);
        check({powered_up, standby}, exp_power(ctrl[1:0], 1'b1));
      end
    join
    check(word, {4'h0, lvl});
    check({sample_hold, dac_code}, {1'b0, lvl});
    check({powered_up, standby}, exp_power(ctrl[1:0], 1'b0));
    check(ref_enable, !ctrl[5] && |exp_power(ctrl[1:0], 1'b0));
    check({use_supply_ref, channel_choice}, {ctrl[4], ctrl[4] & ctrl[3]});
    check(dout_oe, 1'b0);
    apb(1'b0, adc_pkg::ADDR_CONTROL, 32'h0, r, e);
    check(r, {24'h0, ctrl});
    apb(1'b0, adc_pkg::ADDR_RESULT, 32'h0, r, e);
    check(r, {20'h0, lvl});
    apb(1'b0, adc_pkg::ADDR_STATUS, 32'h0, r, e);
    check(r, {22'h0, exp_power(ctrl[1:0], 1'b0), 3'h0, 5'h10});
  endtask : run_frame

  initial
  begin
    #200000;
    miscompares++;
    report_and_stop();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    analog_level = 12'h000;
    miscompares = 0;
    cmp_count = 0;
    rnd = $urandom(32'hf1cc271d);
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    check(powered_up, 1'b0);
    check(dout_oe, 1'b0);
    apb(1'b0, adc_pkg::ADDR_CONTROL, 32'h0, rd, err);
    check(rd, 32'h0);
    apb(1'b1, adc_pkg::ADDR_CONTROL, 32'h01, rd, err);
    repeat (3) @(posedge clk);
    check(powered_up, 1'b1);
    apb(1'b0, 8'h0c, 32'h0, rd, err);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    for (k = 0; k < 12; k++)
    begin
      rnd = $urandom;
      m = (k < 4) ? k[1:0] : rnd[1:0];
      // Reference stays enabled whenever standby is chosen.
      run_frame({rnd[7], 1'b0, (m == 2'b11) ? 1'b0 : rnd[5], rnd[4],
                 rnd[3], 1'b0, m},
                (k < 4) ? corners[k] : rnd[27:16],
                62.5);
    end
    run_frame(8'h00, 12'h5a5, 62.5);
    run_frame(8'h31, 12'h3c3, 62.5);
    run_frame(8'h02, 12'h001, 62.5);
    report_and_stop();
  end
endmodule : serial_adc_power_control_tb
